//--- verilog/cfe_pkg.sv
// Constants, register map and carrier types of the CCD front-end control.
// Assumes one 100 MHz system clock and a three-wire serial link from the controller.
// Function
// - Ten-bit gain code spans 5.3 to 41.105 dB.
// - Gain equals code times 0.035 plus 5.3 dB.
// - Reference and data sampled on active edges, rising only when the polarity bit is 1.
// - Clamp overrides preblank; clamp loop unaffected.
// - Preblank drives every output bit to zero unless the blanking-level bit is set.
// - Output word appears nine data clocks later.
// - Power-on resets registers, calibrates about 1 ms.
// - Serial writes discarded until calibration ends.
// - Blanking-level bit picks zero or clamp level.
// - Bits on serial clock; applied at load strobe.
// - Polarity bits per input, one shared by reference and data; 0 low, 1 high.
package cfe_pkg;
    localparam int WORD_W = 12;
    localparam int ADDR_W = 4;
    localparam int GAIN_W = 10;
    localparam int CLAMP_W = 8;
    localparam int NREG = 5;
    localparam int LATENCY = 9;

    // Register indices 0..4: operation, control, clamp level, gain, startup.
    localparam logic [3:0] REG_ADDR [0:NREG-1] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd};
    localparam logic [11:0] REG_RESET [0:NREG-1] = '{12'h000, 12'h000, 12'h080, 12'h000, 12'h000};
    localparam int IDX_OPERATION = 0;
    localparam int IDX_CONTROL = 1;
    localparam int IDX_CLAMP = 2;
    localparam int IDX_GAIN = 3;
    localparam int IDX_STARTUP = 4;
    localparam logic [11:0] STARTUP_VALUE = 12'h838;

    // Operation register fields.
    localparam int OP_SW_RESET = 0;
    localparam int OP_CLAMP_OFF = 3;
    localparam int OP_BLANK_LEVEL = 6;
    // Control register fields.
    localparam int CTL_POL_SAMPLE = 0;
    localparam int CTL_POL_DCLK = 1;
    localparam int CTL_POL_CLAMP = 2;
    localparam int CTL_POL_BLANK = 3;
    localparam int CTL_TRISTATE = 4;
    localparam int CTL_GRAY = 6;

    // Gain in milli-decibels: code times step plus offset.
    localparam logic [15:0] GAIN_STEP_MDB = 16'h0023;
    localparam logic [15:0] GAIN_OFFSET_MDB = 16'h14b4;

    localparam int SYS_CLK_NS = 10;
    localparam int CAL_TIME_NS = 1000000;
    localparam int CAL_CYCLES = CAL_TIME_NS / SYS_CLK_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } cfe_word_t;

    typedef struct packed {
        logic ref_clk;
        logic dat_clk;
        logic out_clk;
        logic clamp;
        logic blank;
    } cfe_pins_t;
endpackage

//--- verilog/cfe_serial_rx.sv
// Serial receiver on the link clock: address then auto-incrementing 12-bit words.
// Assumes the load strobe is high between frames and the serial clock runs only inside them.
`timescale 1ns/1ps
module cfe_serial_rx (
    input wire logic serial_clock,
    input wire logic rst,
    input wire logic serial_load_strobe,
    input wire logic serial_data_in,
    output cfe_pkg::cfe_word_t word,
    output logic word_tgl
);
    logic [3:0] bit_cnt;
    logic in_data;
    logic [3:0] addr;
    logic [11:0] shreg;
    wire [11:0] next_shreg = {serial_data_in, shreg[11:1]};
    wire addr_done = !in_data && bit_cnt == 4'h3;
    wire word_done = in_data && bit_cnt == 4'hb;

    // The strobe itself ends the frame, so nothing waits on a clock edge after it.
    always_ff @(posedge serial_clock or posedge serial_load_strobe) begin
        if (serial_load_strobe) begin
            bit_cnt <= 4'h0;
            in_data <= 1'b0;
            addr <= 4'h0;
        end else if (addr_done) begin
            bit_cnt <= 4'h0;
            in_data <= 1'b1;
            addr <= next_shreg[11:8];
        end else if (word_done) begin
            bit_cnt <= 4'h0;
            addr <= addr + 4'h1;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge serial_clock) begin
        shreg <= next_shreg;
    end

    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            word <= '0;
            word_tgl <= 1'b0;
        end else if (word_done && !serial_load_strobe) begin
            word <= '{addr: addr, data: next_shreg};
            word_tgl <= !word_tgl;
        end
    end
endmodule

//--- verilog/cfe_pipe.sv
// Fixed-depth output pipeline that advances once per active output data clock edge.
// Assumes shift is a one-cycle strobe on the system clock.
`timescale 1ns/1ps
module cfe_pipe #(
    parameter int W = 12,
    parameter int DEPTH = 9
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic shift,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage [0:DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage[i] <= '0;
            end
        end else if (shift) begin
            stage[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end
    assign dout = stage[DEPTH-1];

    // Tracker follows one word and counts shifts until it must leave.
    logic trk_on;
    logic [W-1:0] trk_val;
    logic [7:0] trk_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trk_on <= 1'b0;
            trk_val <= '0;
            trk_cnt <= 8'h00;
        end else if (shift && !trk_on) begin
            trk_on <= 1'b1;
            trk_val <= din;
            trk_cnt <= 8'h01;
        end else if (shift && trk_on) begin
            trk_on <= trk_cnt != 8'(DEPTH);
            trk_cnt <= trk_cnt + 8'h01;
        end
    end

    property p_latency;
        @(posedge sys_clk) disable iff (rst)
        trk_on && trk_cnt == 8'(DEPTH) && !shift |-> dout == trk_val;
    endproperty
    a_latency: assert property (p_latency) else $error("pipeline latency wrong");
endmodule

//--- verilog/cfe_frontend_ctrl.sv
// Digital control of the CCD front end: pins, sampling, blanking, registers, calibration.
// Assumes conv_sample is on sys_clk; pixel pins are asynchronous; serial_clock is the link clock.
`timescale 1ns/1ps
module cfe_frontend_ctrl #(
    parameter int CAL_CYCLES = cfe_pkg::CAL_CYCLES,
    parameter int LATENCY = cfe_pkg::LATENCY
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_load_strobe,
    input wire logic serial_data_in,
    input wire logic reference_sample_clock,
    input wire logic data_sample_clock,
    input wire logic output_data_clock,
    input wire logic black_clamp_pulse,
    input wire logic preblank_pulse,
    input wire logic [11:0] conv_sample,
    output logic [11:0] data_out,
    output logic data_oe,
    output logic [9:0] gain_code,
    output logic [15:0] gain_mdb,
    output logic [7:0] clamp_level,
    output logic clamp_active,
    output logic cal_busy,
    output logic [11:0] startup_word
);
    localparam int NREG = cfe_pkg::NREG;
    localparam int CW = $clog2(CAL_CYCLES + 1);

    // --------------------------------------------------------------
    // Power-on calibration
    // --------------------------------------------------------------
    logic [CW-1:0] cal_cnt;
    wire cal_last = cal_cnt == CW'(CAL_CYCLES - 1);
    wire [CW-1:0] next_cal_cnt = cal_cnt + CW'(1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cal_cnt <= '0;
            cal_busy <= 1'b1;
        end else if (cal_busy) begin
            cal_cnt <= next_cal_cnt;
            cal_busy <= !cal_last;
        end
    end

    // --------------------------------------------------------------
    // Serial link and crossing
    // --------------------------------------------------------------
    cfe_pkg::cfe_word_t word;
    logic word_tgl;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_q;
    logic sl_s1;
    logic sl_s2;
    logic sl_q;
    logic sl_rise_d;

    cfe_serial_rx u_rx (
        .serial_clock(serial_clock),
        .rst(rst),
        .serial_load_strobe(serial_load_strobe),
        .serial_data_in(serial_data_in),
        .word(word),
        .word_tgl(word_tgl)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_q <= 1'b0;
            sl_s1 <= 1'b1;
            sl_s2 <= 1'b1;
            sl_q <= 1'b1;
            sl_rise_d <= 1'b0;
        end else begin
            tgl_s1 <= word_tgl;
            tgl_s2 <= tgl_s1;
            tgl_q <= tgl_s2;
            sl_s1 <= serial_load_strobe;
            sl_s2 <= sl_s1;
            sl_q <= sl_s2;
            sl_rise_d <= sl_s2 && !sl_q;
        end
    end

    // The word register is stable for many link cycles after its toggle moves.
    wire new_word = (tgl_s2 ^ tgl_q) && !cal_busy;
    // Commit one cycle late so a final word seen with the strobe edge is kept.
    wire commit = sl_rise_d && !cal_busy;

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [11:0] regs [0:NREG-1];
    logic [11:0] pend_val [0:NREG-1];
    logic [NREG-1:0] pend_mask;
    wire [NREG-1:0] addr_hit;
    wire sw_reset = regs[cfe_pkg::IDX_OPERATION][cfe_pkg::OP_SW_RESET];

    for (genvar i = 0; i < NREG; i++) begin : g_dec
        assign addr_hit[i] = word.addr == cfe_pkg::REG_ADDR[i];
    end

    always_ff @(posedge sys_clk) begin
        if (rst || commit) begin
            pend_mask <= '0;
        end else if (new_word) begin
            pend_mask <= pend_mask | addr_hit;
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NREG; i++) begin
            if (rst) begin
                pend_val[i] <= 12'h000;
            end else if (new_word && addr_hit[i]) begin
                pend_val[i] <= word.data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < NREG; i++) begin
            if (rst || sw_reset) begin
                regs[i] <= cfe_pkg::REG_RESET[i];
            end else if (commit && pend_mask[i]) begin
                regs[i] <= pend_val[i];
            end
        end
    end

    wire [11:0] op_reg = regs[cfe_pkg::IDX_OPERATION];
    wire [11:0] ctl_reg = regs[cfe_pkg::IDX_CONTROL];
    assign gain_code = regs[cfe_pkg::IDX_GAIN][9:0];
    assign clamp_level = regs[cfe_pkg::IDX_CLAMP][7:0];
    assign startup_word = regs[cfe_pkg::IDX_STARTUP];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gain_mdb <= cfe_pkg::GAIN_OFFSET_MDB;
        end else begin
            gain_mdb <= 16'(gain_code) * cfe_pkg::GAIN_STEP_MDB + cfe_pkg::GAIN_OFFSET_MDB;
        end
    end

    // --------------------------------------------------------------
    // Pixel pins
    // --------------------------------------------------------------
    cfe_pkg::cfe_pins_t pins_s1;
    cfe_pkg::cfe_pins_t pins_s2;
    cfe_pkg::cfe_pins_t pins_q;
    cfe_pkg::cfe_pins_t act_now;
    cfe_pkg::cfe_pins_t act_prev;
    cfe_pkg::cfe_pins_t act_rise;
    wire [4:0] polv = {ctl_reg[cfe_pkg::CTL_POL_SAMPLE], ctl_reg[cfe_pkg::CTL_POL_SAMPLE],
                       ctl_reg[cfe_pkg::CTL_POL_DCLK], ctl_reg[cfe_pkg::CTL_POL_CLAMP],
                       ctl_reg[cfe_pkg::CTL_POL_BLANK]};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            pins_q <= '0;
        end else begin
            pins_s1 <= '{reference_sample_clock, data_sample_clock, output_data_clock,
                         black_clamp_pulse, preblank_pulse};
            pins_s2 <= pins_s1;
            pins_q <= pins_s2;
        end
    end

    assign act_now = pins_s2 ^ ~polv;
    assign act_prev = pins_q ^ ~polv;
    assign act_rise = act_now & ~act_prev;
    wire clamp_act = act_now.clamp;
    wire blank_act = act_now.blank && !clamp_act;
    assign clamp_active = clamp_act;

    // --------------------------------------------------------------
    // Sampling, clamp loop and blanking
    // --------------------------------------------------------------
    logic [11:0] ref_q;
    logic [11:0] dat_q;
    logic pix_new;
    logic signed [12:0] offset;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_q <= 12'h000;
            dat_q <= 12'h000;
            pix_new <= 1'b0;
        end else begin
            if (act_rise.ref_clk) begin
                ref_q <= conv_sample;
            end
            if (act_rise.dat_clk) begin
                dat_q <= conv_sample;
            end
            pix_new <= act_rise.dat_clk;
        end
    end

    // CCD video falls below the reference, so the pixel is reference minus data.
    wire [12:0] diff = {1'b0, ref_q} - {1'b0, dat_q};
    wire [11:0] raw = diff[12] ? 12'h000 : diff[11:0];
    wire signed [13:0] sum = $signed({2'b00, raw}) + 14'(offset);
    wire [11:0] corrected = sum[13] ? 12'h000 : (sum[12] ? 12'hfff : sum[11:0]);
    wire [11:0] level12 = {4'h0, clamp_level};
    wire loop_on = clamp_act && !op_reg[cfe_pkg::OP_CLAMP_OFF] && pix_new;

    always_ff @(posedge sys_clk) begin
        if (rst || sw_reset) begin
            offset <= 13'sh0000;
        end else if (loop_on && corrected > level12) begin
            offset <= offset - 13'sh0001;
        end else if (loop_on && corrected < level12) begin
            offset <= offset + 13'sh0001;
        end
    end

    wire [11:0] blank_word = op_reg[cfe_pkg::OP_BLANK_LEVEL] ? level12 : 12'h000;
    wire [11:0] pipe_in = blank_act ? blank_word : corrected;
    wire [11:0] pipe_out;

    cfe_pipe #(.W(12), .DEPTH(LATENCY)) u_pipe (
        .sys_clk(sys_clk),
        .rst(rst),
        .shift(act_rise.out_clk),
        .din(pipe_in),
        .dout(pipe_out)
    );

    wire [11:0] coded = ctl_reg[cfe_pkg::CTL_GRAY] ? (pipe_out ^ (pipe_out >> 1)) : pipe_out;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out <= 12'h000;
            data_oe <= 1'b0;
        end else begin
            data_out <= coded;
            data_oe <= !ctl_reg[cfe_pkg::CTL_TRISTATE];
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_cal_len;
        $fell(cal_busy) |-> $past(cal_cnt) == CW'(CAL_CYCLES - 1);
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

    property p_cal_drop;
        cal_busy |=> $stable(gain_code) && $stable(pend_mask);
    endproperty
    a_cal_drop: assert property (p_cal_drop) else $error("write taken during calibration");

    property p_commit;
        commit && pend_mask[cfe_pkg::IDX_GAIN] |=> gain_code == $past(pend_val[cfe_pkg::IDX_GAIN][9:0]);
    endproperty
    a_commit: assert property (p_commit) else $error("gain not applied at load");

    property p_hold;
        !commit && !sw_reset |=> $stable(gain_code) && $stable(clamp_level);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without load");

    property p_gain;
        ##1 gain_mdb == 16'($past(gain_code)) * cfe_pkg::GAIN_STEP_MDB + cfe_pkg::GAIN_OFFSET_MDB;
    endproperty
    a_gain: assert property (p_gain) else $error("gain value mismatch");

    property p_blank_zero;
        act_now.blank && !clamp_act && !op_reg[cfe_pkg::OP_BLANK_LEVEL] |-> pipe_in == 12'h000;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("blank not zero");

    property p_clamp_wins;
        clamp_act |-> pipe_in == corrected;
    endproperty
    a_clamp_wins: assert property (p_clamp_wins) else $error("blank overrode clamp");

    property p_blank_level;
        act_now.blank && !clamp_act && op_reg[cfe_pkg::OP_BLANK_LEVEL] |-> pipe_in == level12;
    endproperty
    a_blank_level: assert property (p_blank_level) else $error("blank level wrong");

    property p_pol;
        $stable(polv) && (polv[4] ? $rose(pins_s2.ref_clk) : $fell(pins_s2.ref_clk)) |-> act_rise.ref_clk;
    endproperty
    a_pol: assert property (p_pol) else $error("reference edge missed");

    property p_sample;
        act_rise.dat_clk |=> dat_q == $past(conv_sample) && pix_new;
    endproperty
    a_sample: assert property (p_sample) else $error("data sample missed");

    c_cal_end: cover property ($fell(cal_busy));
    c_gain_load: cover property (commit && pend_mask[cfe_pkg::IDX_GAIN]);
    c_overlap: cover property (clamp_act && act_now.blank);
    c_blank: cover property (blank_act ##1 act_rise.out_clk);
endmodule

//--- dv/cfe_host_model.sv
// Partner model: the timing generator pins and the serial-writing controller.
// Assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
module cfe_host_model (
    input wire logic sys_clk,
    output logic serial_clock,
    output logic serial_load_strobe,
    output logic serial_data_in,
    output cfe_pkg::cfe_pins_t pins,
    output logic [11:0] conv_sample
);
    initial begin
        serial_clock = 1'b0;
        serial_load_strobe = 1'b1;
        serial_data_in = 1'b0;
        pins = '0;
        conv_sample = 12'h000;
    end

    // ----------------------------------------
    // Serial controller
    // ----------------------------------------
    task automatic send_bit(input logic b);
        serial_data_in = b;
        #40 serial_clock = 1'b1;
        #40 serial_clock = 1'b0;
    endtask

    // Shifts the address and n words LSB first; the strobe stays low afterwards.
    task automatic frame_open(input logic [3:0] a, input logic [11:0] w0, input logic [11:0] w1, input int n);
        @(posedge sys_clk);
        #3 serial_load_strobe = 1'b0;
        #80;
        for (int i = 0; i < 4; i++) begin
            send_bit(a[i]);
        end
        for (int i = 0; i < 12 * n; i++) begin
            send_bit(i < 12 ? w0[i] : w1[i - 12]);
        end
    endtask

    // The clock stands still and the released data line shows the inverse of its last bit.
    task automatic frame_close();
        #40 serial_load_strobe = 1'b1;
        serial_data_in = ~serial_data_in;
        #80;
    endtask

    // ----------------------------------------
    // Pixel timing
    // ----------------------------------------
    task automatic pixel(input logic [11:0] r, input logic [11:0] d, input logic b, input logic c);
        @(posedge sys_clk);
        conv_sample <= r;
        pins.blank <= b;
        pins.clamp <= c;
        pins.ref_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.ref_clk <= 1'b0;
        conv_sample <= d;
        repeat (4) @(posedge sys_clk);
        pins.dat_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.out_clk <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.dat_clk <= 1'b0;
        pins.out_clk <= 1'b0;
        repeat (8) @(posedge sys_clk);
        pins.blank <= 1'b0;
        pins.clamp <= 1'b0;
        conv_sample <= ~d;
    endtask
endmodule

//--- dv/cfe_frontend_ctrl_test.sv
// Self-checking bench of the front-end control against a register and pixel model.
// Assumes the partner model drives every serial and pixel input.
`timescale 1ns/1ps
module cfe_frontend_ctrl_test;
    localparam int CAL = 400;
    logic sys_clk;
    logic rst;
    logic serial_clock, serial_load_strobe, serial_data_in;
    cfe_pkg::cfe_pins_t pins;
    logic [11:0] conv_sample, data_out, startup_word;
    logic data_oe, clamp_active, cal_busy;
    logic [9:0] gain_code;
    logic [15:0] gain_mdb;
    logic [7:0] clamp_level;
    int mismatches = 0;
    int checked = 0;
    int since = 0;
    int cal_done = 0;
    int regs [16];
    int pipe_q [$];
    logic [15:0] seed = 16'h0058;

    cfe_host_model u_cfe_host_model (.sys_clk(sys_clk), .serial_clock(serial_clock),
        .serial_load_strobe(serial_load_strobe), .serial_data_in(serial_data_in), .pins(pins),
        .conv_sample(conv_sample));

    cfe_frontend_ctrl #(.CAL_CYCLES(CAL), .LATENCY(9)) u_cfe_frontend_ctrl (.sys_clk(sys_clk), .rst(rst),
        .serial_clock(serial_clock), .serial_load_strobe(serial_load_strobe), .serial_data_in(serial_data_in),
        .reference_sample_clock(pins.ref_clk), .data_sample_clock(pins.dat_clk),
        .output_data_clock(pins.out_clk), .black_clamp_pulse(pins.clamp), .preblank_pulse(pins.blank),
        .conv_sample(conv_sample), .data_out(data_out), .data_oe(data_oe), .gain_code(gain_code),
        .gain_mdb(gain_mdb), .clamp_level(clamp_level), .clamp_active(clamp_active), .cal_busy(cal_busy),
        .startup_word(startup_word));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        since <= rst ? 0 : since + 1;
    end

    // ----------------------------------------
    // Checking and the behavioural model
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checked++;
        if (seen !== expected) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic give_verdict();
        $display("Checks: %0d mismatches: %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic apply(input int a, input int v);
        if (cal_done == 0) begin
            return;
        end
        if (a == 0 && v % 2 == 1) begin
            regs = '{default: 0};
            regs[2] = 128;
        end else if (a <= 3 || a == 13) begin
            regs[a] = v;
        end
    endtask

    task automatic compare_regs();
        check(16'(gain_code), 16'(regs[3] % 1024));
        check(gain_mdb, 16'((regs[3] % 1024) * 35 + 5300));
        check(16'(clamp_level), 16'(regs[2] % 256));
        check(16'(startup_word), 16'(regs[13]));
    endtask

    task automatic write_regs(input logic [3:0] a, input logic [11:0] w0, input logic [11:0] w1, input int n);
        u_cfe_host_model.frame_open(a, w0, w1, n);
        u_cfe_host_model.frame_close();
        repeat (10) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            apply((a + i) % 16, i == 0 ? w0 : w1);
        end
    endtask

    // Blanking decides at load time: clamp wins, else zero or the clamp level.
    task automatic run_pixel(input int b, input int c, input int inv);
        logic [11:0] r;
        logic [11:0] d;
        int e;
        int x;
        seed = lfsr(seed);
        r = seed[11:0];
        seed = lfsr(seed);
        d = seed[11:0];
        e = r > d ? r - d : 0;
        if (b != 0 && c == 0) begin
            e = regs[0][6] ? regs[2] % 256 : 0;
        end
        u_cfe_host_model.pixel(r, d, 1'(b ^ inv), 1'(c));
        check(16'(clamp_active), 16'(c));
        pipe_q.push_back(e);
        if (pipe_q.size() == 9) begin
            x = pipe_q.pop_front();
            // Output coding is applied as the word leaves, so it follows the current control value.
            if (regs[1][6] == 1'b1) begin
                x = x ^ (x >> 1);
            end
            check(16'(data_out), 16'(x));
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        logic [9:0] code;
        rst = 1'b1;
        regs = '{default: 0};
        regs[2] = 128;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check(16'(cal_busy), 16'h1);
        compare_regs();
        write_regs(4'h3, 12'h155, 12'h000, 1);
        check(16'(cal_busy), 16'h1);
        compare_regs();
        for (n = 0; n < 1000 && cal_busy !== 1'b0; n++) begin
            @(posedge sys_clk);
        end
        check(16'(since >= CAL - 1 && since <= CAL + 2), 16'h1);
        cal_done = 1;
        write_regs(4'hc, 12'h7a5, cfe_pkg::STARTUP_VALUE, 2);
        compare_regs();
        write_regs(4'h0, 12'h008, 12'h00f, 2);
        check(16'(data_oe), 16'h1);
        u_cfe_host_model.frame_open(4'h3, 12'h2aa, 12'h000, 1);
        repeat (10) @(posedge sys_clk);
        compare_regs();
        u_cfe_host_model.frame_close();
        repeat (10) @(posedge sys_clk);
        apply(3, 12'h2aa);
        compare_regs();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            code = i == 0 ? 10'h000 : i == 1 ? 10'h3ff : seed[9:0];
            write_regs(4'h2, {4'h0, seed[15:8]}, {2'b00, code}, 2);
            compare_regs();
        end
        for (int i = 0; i < 12; i++) begin
            run_pixel(i % 3 != 0, i % 3 == 2, 0);
        end
        write_regs(4'h0, 12'h048, 12'h000, 1);
        for (int i = 0; i < 9; i++) begin
            run_pixel(i % 3 != 0, i % 3 == 2, 0);
        end
        write_regs(4'h1, 12'h057, 12'h000, 1);
        check(16'(data_oe), 16'h0);
        for (int i = 0; i < 9; i++) begin
            run_pixel(i % 2, 0, 1);
        end
        write_regs(4'h0, 12'h001, 12'h000, 1);
        compare_regs();
        check(16'(data_oe), 16'h1);
        give_verdict();
    end

    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule
